// >>> rtl/spm_param_mem.sv
// indirectly addressed parameter memory of the light and proximity sensor
// Operation
// - Parameters live in internal memory reachable only by the read and write commands.
// - Entry 0 holds the 8-bit pending bus address and resets to zero.
// - The answering address changes only when the apply command arrives.
// - Channel list bit 6 enables the auxiliary channel, bit 7 is reserved.
// - Channel list bit 5 enables the infrared light channel.
// - Channel list bit 4 enables the visible light channel, bit 3 is reserved.
// - Input selections sit at 0x07, 0x08, 0x09, 0x0E and 0x0F.
// - Hysteresis, history, offset and recovery entries sit at 0x16 to 0x1C.
// - Channel list bits 2, 1 and 0 enable proximity channels 3, 2 and 1.
// - A set low-bits flag reports the low 16 of 17 bits, else the upper 16.
// - Each 3-bit emitter field drives emitters 1 to 3 by its bits, zero drives none.
`timescale 1ns/10ps
module spm_param_mem #(
  parameter int OFFSET_WIDTH = 8,
  parameter logic [7:0] START_BUS_ADDRESS = 8'h2A // arbitrary value
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [OFFSET_WIDTH-1:0] cmd_offset,
  input wire logic [7:0] cmd_wdata,
  input wire logic bus_address_apply_command,
  input wire logic conv_valid,
  input wire spm_pkg::spm_chan_e conv_channel,
  input wire logic [16:0] conv_raw,
  input wire logic led_pulse,
  input wire logic [1:0] led_prox_sel,
  output logic [7:0] read_data,
  output logic read_valid,
  output logic [7:0] active_bus_address,
  output logic prox1_channel_enable,
  output logic prox2_channel_enable,
  output logic prox3_channel_enable,
  output logic visible_light_channel_enable,
  output logic ir_light_channel_enable,
  output logic aux_channel_enable,
  output logic [7:0] prox1_input_select,
  output logic [7:0] prox2_input_select,
  output logic [7:0] prox3_input_select,
  output logic [7:0] ir_light_input_select,
  output logic [7:0] aux_input_select,
  output logic [7:0] light_hysteresis,
  output logic [7:0] prox_hysteresis,
  output logic [7:0] prox_history_setting,
  output logic [7:0] light_history_setting,
  output logic [7:0] conversion_offset,
  output logic [7:0] emitter_recovery_time,
  output logic result_valid,
  output spm_pkg::spm_chan_e result_channel,
  output logic [15:0] result_data,
  output logic [2:0] emitter_drive
);
  if (OFFSET_WIDTH < 5)
  begin : g_check
    $error("offset port too narrow for 32 entries");
  end

  logic [spm_pkg::NUM_ENTRIES-1:0][7:0] mem;

  // offset decode; upper offset bits must be zero to hit an entry
  wire logic [4:0] entry_ofs = cmd_offset[4:0];
  wire logic in_range = (cmd_offset >> 5) == '0;
  wire logic do_write = cmd_valid && cmd_write && in_range;
  wire logic do_read = cmd_valid && !cmd_write;
  wire logic [7:0] entry_value = mem[entry_ofs];
  // out of range reads answer zero rather than alias a real entry
  wire logic [7:0] next_read_data = in_range ? (cmd_write ? cmd_wdata : entry_value) : 8'h00;

  // named views of the entries
  wire logic [7:0] chan_list = mem[spm_pkg::OFS_CHANNEL_LIST];
  wire logic [7:0] led12 = mem[spm_pkg::OFS_LED_PROX12];
  wire logic [7:0] led3 = mem[spm_pkg::OFS_LED_PROX3];
  wire logic [7:0] prox_align = mem[spm_pkg::OFS_PROX_ALIGN];
  wire logic [7:0] light_align = mem[spm_pkg::OFS_LIGHT_ALIGN];

  // the parameter store itself; reserved bits are kept as written
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < spm_pkg::NUM_ENTRIES; i++)
      begin
        mem[i] <= spm_pkg::spm_reset_value(5'(i));
      end
    end
    else if (do_write)
    begin
      mem[entry_ofs] <= cmd_wdata;
    end
  end

  // command answer; a write echoes the value taken
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      read_data <= spm_pkg::RST_READ_DATA;
      read_valid <= 1'b0;
    end
    else
    begin
      read_valid <= do_read || (cmd_valid && cmd_write);
      if (cmd_valid)
      begin
        read_data <= next_read_data;
      end
    end
  end

  // answering address only follows the stored one on the apply command
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      active_bus_address <= START_BUS_ADDRESS;
    end
    else if (bus_address_apply_command)
    begin
      active_bus_address <= mem[spm_pkg::OFS_BUS_ADDRESS];
    end
  end

  // channel list decode
  assign aux_channel_enable = chan_list[spm_pkg::BIT_AUX_EN];
  assign ir_light_channel_enable = chan_list[spm_pkg::BIT_IR_EN];
  assign visible_light_channel_enable = chan_list[spm_pkg::BIT_VIS_EN];
  assign prox3_channel_enable = chan_list[spm_pkg::BIT_PROX3_EN];
  assign prox2_channel_enable = chan_list[spm_pkg::BIT_PROX2_EN];
  assign prox1_channel_enable = chan_list[spm_pkg::BIT_PROX1_EN];

  // settings handed to the analogue path
  assign prox1_input_select = mem[spm_pkg::OFS_PROX1_INPUT];
  assign prox2_input_select = mem[spm_pkg::OFS_PROX2_INPUT];
  assign prox3_input_select = mem[spm_pkg::OFS_PROX3_INPUT];
  assign ir_light_input_select = mem[spm_pkg::OFS_IR_INPUT];
  assign aux_input_select = mem[spm_pkg::OFS_AUX_INPUT];
  assign light_hysteresis = mem[spm_pkg::OFS_LIGHT_HYST];
  assign prox_hysteresis = mem[spm_pkg::OFS_PROX_HYST];
  assign prox_history_setting = mem[spm_pkg::OFS_PROX_HISTORY];
  assign light_history_setting = mem[spm_pkg::OFS_LIGHT_HISTORY];
  assign conversion_offset = mem[spm_pkg::OFS_CONV_OFFSET];
  assign emitter_recovery_time = mem[spm_pkg::OFS_EMITTER_RECOVERY];

  // per-channel enable and low-bits flag of the incoming conversion
  logic chan_enabled;
  logic chan_low;
  always_comb
  begin
    chan_enabled = 1'b0;
    chan_low = 1'b0;
    unique case (conv_channel)
      spm_pkg::SPM_CH_PROX1:
      begin
        chan_enabled = chan_list[spm_pkg::BIT_PROX1_EN];
        chan_low = prox_align[spm_pkg::BIT_PROX1_LOW];
      end
      spm_pkg::SPM_CH_PROX2:
      begin
        chan_enabled = chan_list[spm_pkg::BIT_PROX2_EN];
        chan_low = prox_align[spm_pkg::BIT_PROX2_LOW];
      end
      spm_pkg::SPM_CH_PROX3:
      begin
        chan_enabled = chan_list[spm_pkg::BIT_PROX3_EN];
        chan_low = prox_align[spm_pkg::BIT_PROX3_LOW];
      end
      spm_pkg::SPM_CH_VIS:
      begin
        chan_enabled = chan_list[spm_pkg::BIT_VIS_EN];
        chan_low = light_align[spm_pkg::BIT_VIS_LOW];
      end
      spm_pkg::SPM_CH_IR:
      begin
        chan_enabled = chan_list[spm_pkg::BIT_IR_EN];
        chan_low = light_align[spm_pkg::BIT_IR_LOW];
      end
      spm_pkg::SPM_CH_AUX:
      begin
        // auxiliary has no flag, so it always reports the upper bits
        chan_enabled = chan_list[spm_pkg::BIT_AUX_EN];
      end
      default:
      begin
        chan_enabled = 1'b0;
      end
    endcase
  end

  logic [15:0] aligned;
  spm_align #(
    .RAW_W(spm_pkg::RAW_WIDTH)
  ) u_align (
    .low_bits(chan_low),
    .raw(conv_raw),
    .result(aligned)
  );

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      result_valid <= 1'b0;
      result_channel <= spm_pkg::SPM_CH_PROX1;
      result_data <= '0;
    end
    else
    begin
      // conversions on disabled channels are dropped
      result_valid <= conv_valid && chan_enabled;
      if (conv_valid && chan_enabled)
      begin
        result_channel <= conv_channel;
        result_data <= aligned;
      end
    end
  end

  // emitter selection for the proximity measurement in progress
  logic [2:0] drive_p1;
  logic [2:0] drive_p2;
  logic [2:0] drive_p3;
  wire logic pulse_p1 = led_pulse && led_prox_sel == 2'h1;
  wire logic pulse_p2 = led_pulse && led_prox_sel == 2'h2;
  wire logic pulse_p3 = led_pulse && led_prox_sel == 2'h3;
  spm_led_decode #(.LEDS(3)) u_led1 (
    .active(pulse_p1),
    .field(led12[spm_pkg::POS_PROX1_LED +: 3]),
    .drive(drive_p1)
  );
  spm_led_decode #(.LEDS(3)) u_led2 (
    .active(pulse_p2),
    .field(led12[spm_pkg::POS_PROX2_LED +: 3]),
    .drive(drive_p2)
  );
  spm_led_decode #(.LEDS(3)) u_led3 (
    .active(pulse_p3),
    .field(led3[spm_pkg::POS_PROX3_LED +: 3]),
    .drive(drive_p3)
  );

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      emitter_drive <= 3'h0;
    end
    else
    begin
      emitter_drive <= drive_p1 | drive_p2 | drive_p3;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  store_write_a: assert property (
    do_write |=> mem[$past(entry_ofs)] == $past(cmd_wdata))
    else $error("written entry does not hold the written value");

  range_guard_a: assert property (
    (cmd_valid && cmd_write && !in_range) |=> $stable(mem))
    else $error("out of range write changed the store");

  addr_reset_a: assert property (
    !$past(reset_n) |-> mem[spm_pkg::OFS_BUS_ADDRESS] == 8'h00)
    else $error("pending address not zero after reset");

  addr_hold_a: assert property (
    !bus_address_apply_command |=> $stable(active_bus_address))
    else $error("answering address moved without the apply command");

  addr_apply_a: assert property (
    bus_address_apply_command |=> active_bus_address == $past(mem[spm_pkg::OFS_BUS_ADDRESS]))
    else $error("apply command did not take the stored address");

  aux_gate_a: assert property (
    (conv_valid && conv_channel == spm_pkg::SPM_CH_AUX && !chan_list[6]) |=> !result_valid)
    else $error("auxiliary result passed while disabled");

  ir_gate_a: assert property (
    (conv_valid && conv_channel == spm_pkg::SPM_CH_IR && chan_list[5]) |=> result_valid)
    else $error("enabled infrared result was dropped");

  vis_gate_a: assert property (
    (conv_valid && conv_channel == spm_pkg::SPM_CH_VIS && !chan_list[4]) |=> !result_valid)
    else $error("visible result passed while disabled");

  prox_gate_a: assert property (
    (conv_valid && conv_channel == spm_pkg::SPM_CH_PROX3 && chan_list[2]) |=> result_valid)
    else $error("enabled proximity 3 result was dropped");

  align_low_a: assert property (
    (conv_valid && chan_enabled && chan_low) |=> result_data == $past(conv_raw[15:0]))
    else $error("low-bits flag did not report the low 16 bits");

  align_high_a: assert property (
    (conv_valid && chan_enabled && !chan_low) |=> result_data == $past(conv_raw[16:1]))
    else $error("clear flag did not report the upper 16 bits");

  led_drive_a: assert property (
    (led_pulse && led_prox_sel == 2'h2) |=> emitter_drive == $past(led12[6:4]))
    else $error("proximity 2 emitters do not follow their field");

  led_idle_a: assert property (
    !led_pulse |=> emitter_drive == 3'h0)
    else $error("emitter driven outside a pulse");
endmodule

// >>> rtl/spm_pkg.sv
// constants and types for the sensor parameter memory
package spm_pkg;
  localparam int NUM_ENTRIES = 32;
  localparam int ENTRY_WIDTH = 8;
  localparam int RAW_WIDTH = 17;
  localparam int RESULT_WIDTH = 16;

  // entry offsets
  localparam logic [4:0] OFS_BUS_ADDRESS = 5'h00;
  localparam logic [4:0] OFS_CHANNEL_LIST = 5'h01;
  localparam logic [4:0] OFS_LED_PROX12 = 5'h02;
  localparam logic [4:0] OFS_LED_PROX3 = 5'h03;
  localparam logic [4:0] OFS_RSVD_ZERO_04 = 5'h04;
  localparam logic [4:0] OFS_PROX_ALIGN = 5'h05;
  localparam logic [4:0] OFS_LIGHT_ALIGN = 5'h06;
  localparam logic [4:0] OFS_PROX1_INPUT = 5'h07;
  localparam logic [4:0] OFS_PROX2_INPUT = 5'h08;
  localparam logic [4:0] OFS_PROX3_INPUT = 5'h09;
  localparam logic [4:0] OFS_PROX_COUNTER = 5'h0A;
  localparam logic [4:0] OFS_PROX_GAIN = 5'h0B;
  localparam logic [4:0] OFS_PROX_MISC = 5'h0C;
  localparam logic [4:0] OFS_RSVD_0D = 5'h0D;
  localparam logic [4:0] OFS_IR_INPUT = 5'h0E;
  localparam logic [4:0] OFS_AUX_INPUT = 5'h0F;
  localparam logic [4:0] OFS_VIS_COUNTER = 5'h10;
  localparam logic [4:0] OFS_VIS_GAIN = 5'h11;
  localparam logic [4:0] OFS_VIS_MISC = 5'h12;
  localparam logic [4:0] OFS_RSVD_13 = 5'h13;
  localparam logic [4:0] OFS_RSVD_14 = 5'h14;
  localparam logic [4:0] OFS_RSVD_15 = 5'h15;
  localparam logic [4:0] OFS_LIGHT_HYST = 5'h16;
  localparam logic [4:0] OFS_PROX_HYST = 5'h17;
  localparam logic [4:0] OFS_PROX_HISTORY = 5'h18;
  localparam logic [4:0] OFS_LIGHT_HISTORY = 5'h19;
  localparam logic [4:0] OFS_CONV_OFFSET = 5'h1A;
  localparam logic [4:0] OFS_RSVD_1B = 5'h1B;
  localparam logic [4:0] OFS_EMITTER_RECOVERY = 5'h1C;
  localparam logic [4:0] OFS_IR_COUNTER = 5'h1D;
  localparam logic [4:0] OFS_IR_GAIN = 5'h1E;
  localparam logic [4:0] OFS_IR_MISC = 5'h1F;

  // channel list bit positions
  localparam int BIT_PROX1_EN = 0;
  localparam int BIT_PROX2_EN = 1;
  localparam int BIT_PROX3_EN = 2;
  localparam int BIT_VIS_EN = 4;
  localparam int BIT_IR_EN = 5;
  localparam int BIT_AUX_EN = 6;

  // alignment flag positions
  localparam int BIT_PROX1_LOW = 4;
  localparam int BIT_PROX2_LOW = 5;
  localparam int BIT_PROX3_LOW = 6;
  localparam int BIT_VIS_LOW = 4;
  localparam int BIT_IR_LOW = 5;

  // emitter select field positions
  localparam int POS_PROX1_LED = 0;
  localparam int POS_PROX2_LED = 4;
  localparam int POS_PROX3_LED = 0;

  // values after reset
  localparam logic [7:0] RST_BUS_ADDRESS = 8'h00;
  localparam logic [7:0] RST_LED_PROX12 = 8'h21;
  localparam logic [7:0] RST_RSVD_0D = 8'h02;
  localparam logic [7:0] RST_RSVD_13 = 8'h40;
  localparam logic [7:0] RST_OTHER = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  typedef enum logic [2:0] {
    SPM_CH_PROX1,
    SPM_CH_PROX2,
    SPM_CH_PROX3,
    SPM_CH_VIS,
    SPM_CH_IR,
    SPM_CH_AUX
  } spm_chan_e;

  function automatic logic [7:0] spm_reset_value(input logic [4:0] ofs);
    logic [7:0] value;
    value = RST_OTHER;
    if (ofs == OFS_BUS_ADDRESS)
    begin
      value = RST_BUS_ADDRESS;
    end
    else if (ofs == OFS_LED_PROX12)
    begin
      value = RST_LED_PROX12;
    end
    else if (ofs == OFS_RSVD_0D)
    begin
      value = RST_RSVD_0D;
    end
    else if (ofs == OFS_RSVD_13)
    begin
      value = RST_RSVD_13;
    end
    return value;
  endfunction
endpackage

// >>> rtl/spm_align.sv
// picks the reported 16 bits out of a 17-bit conversion
`timescale 1ns/10ps
module spm_align #(
  parameter int RAW_W = 17
) (
  input wire logic low_bits,
  input wire logic [RAW_W-1:0] raw,
  output logic [RAW_W-2:0] result
);
  if (RAW_W < 2)
  begin : g_check
    $error("spm_align needs at least two raw bits");
  end

  // low flag keeps the fine bits and lets the top bit wrap away
  assign result = low_bits ? raw[RAW_W-2:0] : raw[RAW_W-1:1];
endmodule

// >>> rtl/spm_led_decode.sv
// turns one emitter select field into per-emitter drive enables
`timescale 1ns/10ps
module spm_led_decode #(
  parameter int LEDS = 3
) (
  input wire logic active,
  input wire logic [LEDS-1:0] field,
  output logic [LEDS-1:0] drive
);
  if (LEDS < 1)
  begin : g_check
    $error("spm_led_decode needs at least one emitter");
  end

  // each set bit drives its emitter, any mix allowed, zero drives none
  assign drive = active ? field : '0;
endmodule

// >>> bench/spm_host_model.sv
// host side model that issues parameter commands to the memory
`timescale 1ns/10ps
module spm_host_model (
  input wire logic clock,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_offset,
  output logic [7:0] cmd_wdata,
  output logic bus_address_apply_command,
  input wire logic [7:0] read_data,
  input wire logic read_valid
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_offset = 8'h00;
    cmd_wdata = 8'h00;
    bus_address_apply_command = 1'b0;
  end

  // entries are reached by these commands only, never by a direct address
  task automatic send(input logic wr, input logic [7:0] ofs, input logic [7:0] data,
    output logic [7:0] answer, output logic answered);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_offset = ofs;
    cmd_wdata = data;
    @(negedge clock);
    answered = read_valid;
    answer = read_data;
    cmd_valid = 1'b0;
    // stale data is inverted so a late capture cannot pass by luck
    cmd_wdata = ~data;
  endtask

  task automatic apply_address();
    @(negedge clock);
    bus_address_apply_command = 1'b1;
    @(negedge clock);
    bus_address_apply_command = 1'b0;
  endtask
endmodule

// >>> bench/tb_sensor_parameter_memory.sv
// self-checking bench for the sensor parameter memory
`timescale 1ns/10ps
module tb_sensor_parameter_memory;
  localparam logic [7:0] START_ADDR = 8'h2A; // arbitrary value
  localparam logic [4:0] SEL_OFS [11] = '{5'h07, 5'h08, 5'h09, 5'h0E, 5'h0F, 5'h16, 5'h17,
    5'h18, 5'h19, 5'h1A, 5'h1C};
  logic clock, reset_n, cmd_valid, cmd_write, apply, conv_valid, led_pulse;
  logic read_valid, result_valid;
  logic [7:0] cmd_offset, cmd_wdata, read_data, active_bus_address;
  logic [16:0] conv_raw;
  logic [1:0] led_prox_sel;
  logic [15:0] result_data;
  logic [2:0] emitter_drive;
  logic [5:0] en;
  logic [7:0] sel_out [11];
  logic [7:0] exp_mem [32];
  spm_pkg::spm_chan_e conv_channel, result_channel;
  int n_errors, n_compared, cycles;

  spm_host_model spm_host_model_inst (
    .clock(clock), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_offset(cmd_offset),
    .cmd_wdata(cmd_wdata), .bus_address_apply_command(apply), .read_data(read_data),
    .read_valid(read_valid));

  spm_param_mem #(.OFFSET_WIDTH(8), .START_BUS_ADDRESS(START_ADDR)) spm_param_mem_inst (
    .clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_offset(cmd_offset), .cmd_wdata(cmd_wdata), .bus_address_apply_command(apply),
    .conv_valid(conv_valid), .conv_channel(conv_channel), .conv_raw(conv_raw),
    .led_pulse(led_pulse), .led_prox_sel(led_prox_sel), .read_data(read_data),
    .read_valid(read_valid), .active_bus_address(active_bus_address),
    .prox1_channel_enable(en[0]), .prox2_channel_enable(en[1]),
    .prox3_channel_enable(en[2]), .visible_light_channel_enable(en[3]),
    .ir_light_channel_enable(en[4]), .aux_channel_enable(en[5]),
    .prox1_input_select(sel_out[0]), .prox2_input_select(sel_out[1]),
    .prox3_input_select(sel_out[2]), .ir_light_input_select(sel_out[3]),
    .aux_input_select(sel_out[4]), .light_hysteresis(sel_out[5]),
    .prox_hysteresis(sel_out[6]), .prox_history_setting(sel_out[7]),
    .light_history_setting(sel_out[8]), .conversion_offset(sel_out[9]),
    .emitter_recovery_time(sel_out[10]), .result_valid(result_valid),
    .result_channel(result_channel), .result_data(result_data),
    .emitter_drive(emitter_drive));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // generous ceiling: the whole sequence needs well under 3000 cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      $display("MISMATCH at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic logic [7:0] rst_val(input logic [4:0] o);
    return (o == 5'h02) ? 8'h21 : (o == 5'h0D) ? 8'h02 : (o == 5'h13) ? 8'h40 : 8'h00;
  endfunction

  // bits the host may set; zero marks an entry it must leave alone
  function automatic logic [7:0] legal(input logic [4:0] o);
    case (o)
      5'h01, 5'h02: return 8'h77;
      5'h03: return 8'h07;
      5'h04, 5'h0D, 5'h13, 5'h14, 5'h15, 5'h1B: return 8'h00;
      5'h05, 5'h0A, 5'h10, 5'h1D: return 8'h70;
      5'h06: return 8'h30;
      5'h0B, 5'h11, 5'h1E: return 8'h0F;
      5'h0C: return 8'h24;
      5'h12, 5'h1F: return 8'h20;
      default: return 8'hFF;
    endcase
  endfunction

  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] echo;
    logic ok;
    spm_host_model_inst.send(1'b1, ofs, d, echo, ok);
    check({15'h0000, ok}, 16'h0001, "write strobe");
    check({8'h00, echo}, {8'h00, (ofs < 8'h20) ? d : 8'h00}, "write echo");
    if (ofs < 8'h20)
    begin
      exp_mem[ofs[4:0]] = d;
    end
  endtask

  task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] got;
    logic ok;
    spm_host_model_inst.send(1'b0, ofs, 8'h00, got, ok);
    check({15'h0000, ok}, 16'h0001, "read strobe");
    check({8'h00, got}, {8'h00, exp}, "read data");
  endtask

  task automatic verify_all();
    for (int o = 0; o < 32; o++)
    begin
      rd({3'h0, o[4:0]}, exp_mem[o]);
    end
  endtask

  task automatic conv(input int c, input logic [16:0] raw, input logic hit,
    input logic [15:0] exp);
    @(negedge clock);
    conv_valid = 1'b1;
    conv_channel = spm_pkg::spm_chan_e'(c[2:0]);
    conv_raw = raw;
    @(negedge clock);
    conv_valid = 1'b0;
    check({15'h0000, result_valid}, {15'h0000, hit}, "result strobe");
    check(result_data, exp, "result data");
    if (hit)
    begin
      check({13'h0000, result_channel}, {13'h0000, c[2:0]}, "result channel");
    end
  endtask

  initial
  begin
    logic [16:0] raw;
    logic [15:0] expv, last;
    logic [7:0] bad [4];
    bad = '{8'h20, 8'h3F, 8'h80, 8'hFF};
    reset_n = 1'b0;
    conv_valid = 1'b0;
    conv_channel = spm_pkg::SPM_CH_PROX1;
    conv_raw = 17'h00000;
    led_pulse = 1'b0;
    led_prox_sel = 2'h0;
    n_errors = 0;
    n_compared = 0;
    cycles = 0;
    last = 16'h0000;
    for (int i = 0; i < 32; i++) exp_mem[i] = rst_val(i[4:0]);
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    verify_all();
    check({8'h00, active_bus_address}, {8'h00, START_ADDR}, "address");
    check({10'h000, en}, 16'h0000, "enables");
    $display("test reset values done");

    wr(8'h04, 8'h00);
    for (int o = 0; o < 32; o++)
    begin
      if (legal(o[4:0]) != 8'h00)
      begin
        wr({3'h0, o[4:0]}, legal(o[4:0]) & ({o[2:0], o[4:0]} ^ 8'h96));
      end
    end
    verify_all();
    for (int k = 0; k < 11; k++)
    begin
      check({8'h00, sel_out[k]}, {8'h00, exp_mem[SEL_OFS[k]]}, "setting");
    end
    check({10'h000, en}, {10'h000, exp_mem[1][6:4], exp_mem[1][2:0]}, "enables");
    check({8'h00, active_bus_address}, {8'h00, START_ADDR}, "address");
    spm_host_model_inst.apply_address();
    check({8'h00, active_bus_address}, {8'h00, exp_mem[0]}, "applied");
    $display("test write and read back done");

    for (int i = 0; i < 4; i++)
    begin
      wr(bad[i], 8'hFF);
      rd(bad[i], 8'h00);
    end
    verify_all();
    $display("test out of range done");

    for (int c = 0; c < 6; c++)
    begin
      wr(8'h01, 8'h01 << (c < 3 ? c : c + 1));
      for (int f = 0; f < 2; f++)
      begin
        wr(8'h05, f == 0 ? 8'h00 : c < 3 ? 8'h10 << c : c == 5 ? 8'h70 : 8'h00);
        wr(8'h06, f == 0 ? 8'h00 : c == 3 ? 8'h10 : c == 4 ? 8'h20 : 8'h30);
        raw = 17'h1B3C5 ^ {13'h0000, c[2:0], f[0]};
        expv = (f == 1 && c != 5) ? raw[15:0] : raw[16:1];
        for (int q = 0; q < 8; q++)
        begin
          conv(q, raw, q == c, q == c ? expv : last);
          last = (q == c) ? expv : last;
        end
      end
    end
    $display("test conversions done");

    for (int v = 0; v < 8; v++)
    begin
      wr(8'h02, {1'b0, v[2:0], 1'b0, ~v[2:0]});
      wr(8'h03, {5'h00, v[2:0] ^ 3'h5});
      for (int s = 0; s < 4; s++)
      begin
        @(negedge clock);
        led_pulse = 1'b1;
        led_prox_sel = s[1:0];
        @(negedge clock);
        check({13'h0000, emitter_drive}, {13'h0000, (s == 0 ? 3'h0 : s == 1 ? ~v[2:0] :
          s == 2 ? v[2:0] : v[2:0] ^ 3'h5)}, "emitters");
      end
      @(negedge clock);
      led_pulse = 1'b0;
      @(negedge clock);
      check({13'h0000, emitter_drive}, 16'h0000, "emitters idle");
    end
    $display("test emitters done");

    // reset in mid-run must bring written entries back to their defaults
    reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      exp_mem[i] = rst_val(i[4:0]);
    end
    verify_all();
    check({8'h00, active_bus_address}, {8'h00, START_ADDR}, "address");
    check({10'h000, en}, 16'h0000, "enables");
    check({13'h0000, emitter_drive}, 16'h0000, "emitters idle");
    $display("test reset in mid-run done");
    tally_and_finish();
  end
endmodule
